// [rxpm_byte_select.sv]
// Purpose: per-byte mask lookup and comparison window for a pattern byte index
// Assumes: index counts bytes after the frame delimiter from zero
// Notes: outputs registered, one cycle after the query
`timescale 1ns/1ps
`default_nettype none
module rxpm_byte_select
	import rxpm_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// configuration
	input  wire logic [PAT_BYTES-1:0]  mask_flat,
	input  wire logic [START_W-1:0]    start_point,
	// query
	input  wire logic                  query_valid,
	input  wire logic [IDX_W-1:0]      byte_idx,
	// answer
	output logic                       ans_valid,
	output logic                       ans_masked,
	output logic                       ans_in_window
);

	typedef struct packed {
		logic valid;
		logic masked;
		logic in_window;
	} rxpm_sel_state_type;

	rxpm_sel_state_type st_r;
	rxpm_sel_state_type st_nxt;

	// flat bit i of register k is byte 16*k+i, so the index selects directly
	always_comb begin
		st_nxt           = st_r;
		st_nxt.valid     = query_valid;
		if (query_valid) begin
			st_nxt.masked    = mask_flat[byte_idx];
			st_nxt.in_window = (byte_idx >= start_point);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ans_valid     = st_r.valid;
	assign ans_masked    = st_r.masked;
	assign ans_in_window = st_r.in_window;

endmodule
`default_nettype wire

// [rxpm_config_bank.sv]
// Purpose: receive pattern mask, start point, pin clock and low power signal registers
// Assumes: management accesses arrive as one-cycle request strobes with device select
// Notes: device select 1 is forwarded to the medium attachment area, others hit this bank
`timescale 1ns/1ps
`default_nettype none
module rxpm_config_bank
	import rxpm_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// strap sampled while reset is high
	input  wire logic [CLKSEL_W-1:0]   clksel_strap,
	// management request
	input  wire logic                  mgmt_req,
	input  wire logic                  mgmt_write,
	input  wire logic [DEV_W-1:0]      mmd_device_select,
	input  wire logic [ADDR_W-1:0]     mgmt_addr,
	input  wire logic [DATA_W-1:0]     mgmt_wdata,
	// management answer
	output logic                       mgmt_rvalid,
	output logic [DATA_W-1:0]          mgmt_rdata,
	// medium attachment area port
	output logic                       pma_req,
	output logic                       pma_write,
	output logic [ADDR_W-1:0]          pma_addr,
	output logic [DATA_W-1:0]          pma_wdata,
	input  wire logic                  pma_rvalid,
	input  wire logic [DATA_W-1:0]     pma_rdata,
	// configuration towards the compare engine
	output logic [PAT_BYTES-1:0]       pattern_mask,
	output logic [START_W-1:0]         compare_start,
	output logic                       low_power_signal_scrambled,
	output logic [LPWR_W-1:0]          low_power_signal_mode,
	// receive data bit three pin
	input  wire logic                  rx_data_bit_three_in,
	output logic                       receive_data_bit_three,
	output logic                       rmii_master_clk_en,
	// byte query from the compare engine
	input  wire logic                  byte_query_valid,
	input  wire logic [IDX_W-1:0]      byte_query_idx,
	output logic                       byte_ans_valid,
	output logic                       byte_ans_masked,
	output logic                       byte_ans_in_window
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [MASK_REGS-1:0][DATA_W-1:0] mask;
		logic [START_W-1:0]               start;
		logic [DATA_W-1:0]                pin_func;
		logic [DATA_W-1:0]                lpwr;
		logic                             rvalid;
		logic [DATA_W-1:0]                rdata;
		logic                             pma_req;
		logic                             pma_write;
		logic [ADDR_W-1:0]                pma_addr;
		logic [DATA_W-1:0]                pma_wdata;
		logic [DIV_W-1:0]                 div;
		logic                             clk50;
		logic                             pin;
		logic                             clk_en;
		logic                             lpwr_scr;
	} rxpm_bank_state_type;

	rxpm_bank_state_type st_r;
	rxpm_bank_state_type st_nxt;

	////////////////////////////////////////////////////////////////////////////////

	// mask register index from an address, or MASK_REGS when the address is no mask
	function automatic logic [2:0] mask_slot(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFS_MASK_BASE;
		if (a >= OFS_MASK_BASE && d < ADDR_W'(MASK_REGS)) begin
			mask_slot = d[2:0];
		end else begin
			mask_slot = 3'(MASK_REGS);
		end
	endfunction

	// read value of the main space, zero for unmapped words
	function automatic logic [DATA_W-1:0] read_word(input rxpm_bank_state_type s,
	                                               input logic [ADDR_W-1:0] a);
		logic [2:0] k;
		k = mask_slot(a);
		read_word = '0;
		if (k != 3'(MASK_REGS)) begin
			read_word = s.mask[k[1:0]];
		end else if (a == OFS_START) begin
			read_word = {{(DATA_W-START_W){1'b0}}, s.start}; // upper bits read zero
		end else if (a == OFS_PIN_FUNC) begin
			read_word = s.pin_func;
		end else if (a == OFS_LOW_PWR) begin
			read_word = s.lpwr;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic       to_pma;
	logic       to_bank;
	logic [2:0] wslot;

	assign to_pma  = mgmt_req && (mmd_device_select == DEV_PMA);
	assign to_bank = mgmt_req && (mmd_device_select != DEV_PMA);
	assign wslot   = mask_slot(mgmt_addr);

	// next state of the whole bank
	always_comb begin
		st_nxt           = st_r;
		st_nxt.rvalid    = 1'b0;
		st_nxt.pma_req   = 1'b0;

		// forward selected accesses untouched; the far area answers in its own time
		if (to_pma) begin
			st_nxt.pma_req   = 1'b1;
			st_nxt.pma_write = mgmt_write;
			st_nxt.pma_addr  = mgmt_addr;
			st_nxt.pma_wdata = mgmt_wdata;
		end
		if (pma_rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = pma_rdata;
		end

		// local writes; reads answer in the next cycle
		if (to_bank && mgmt_write) begin
			for (int k = 0; k < MASK_REGS; k++) begin
				if (wslot == 3'(k)) begin
					st_nxt.mask[k] = mgmt_wdata;
				end
			end
			if (mgmt_addr == OFS_START) begin
				st_nxt.start = mgmt_wdata[START_LSB +: START_W];
			end
			if (mgmt_addr == OFS_PIN_FUNC) begin
				st_nxt.pin_func = mgmt_wdata;
			end
			if (mgmt_addr == OFS_LOW_PWR) begin
				st_nxt.lpwr = mgmt_wdata;
			end
		end else if (to_bank) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = read_word(st_r, mgmt_addr);
		end

		// 50 MHz from the 200 MHz clock: flip every CLKOUT_HALF cycles
		if (st_r.div == DIV_W'(CLKOUT_HALF - 1)) begin
			st_nxt.div   = '0;
			st_nxt.clk50 = ~st_r.clk50;
		end else begin
			st_nxt.div = st_r.div + DIV_W'(1);
		end

		// pin function; codes other than the two known ones hold the data path
		st_nxt.clk_en = (st_r.pin_func[CLKSEL_W-1:0] == CLKSEL_CLK50);
		if (st_nxt.clk_en) begin
			st_nxt.pin = st_nxt.clk50;
		end else begin
			st_nxt.pin = rx_data_bit_three_in;
		end

		// only code 11 is defined; reserved codes leave the selector off
		st_nxt.lpwr_scr = (st_r.lpwr[LPWR_LSB +: LPWR_W] == LPWR_SCRAMBLED);
	end

	// register the bank; the strap is caught on the synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r       <= '0;
			st_r.mask  <= {MASK_REGS{RST_MASK}};
			st_r.start <= RST_START;
			st_r.pin_func <= {{(DATA_W-CLKSEL_W){1'b0}}, clksel_strap};
			st_r.lpwr     <= RST_LPWR;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// per-byte lookup for the compare engine
	rxpm_byte_select u_sel (
		.clk           (clk),
		.rst           (rst),
		.mask_flat     (st_r.mask),
		.start_point   (st_r.start),
		.query_valid   (byte_query_valid),
		.byte_idx      (byte_query_idx),
		.ans_valid     (byte_ans_valid),
		.ans_masked    (byte_ans_masked),
		.ans_in_window (byte_ans_in_window)
	);

	// outputs straight from flip-flops
	assign mgmt_rvalid                = st_r.rvalid;
	assign mgmt_rdata                 = st_r.rdata;
	assign pma_req                    = st_r.pma_req;
	assign pma_write                  = st_r.pma_write;
	assign pma_addr                   = st_r.pma_addr;
	assign pma_wdata                  = st_r.pma_wdata;
	assign pattern_mask               = st_r.mask;
	assign compare_start              = st_r.start;
	assign low_power_signal_scrambled = st_r.lpwr_scr;
	assign low_power_signal_mode      = st_r.lpwr[LPWR_LSB +: LPWR_W];
	assign receive_data_bit_three     = st_r.pin;
	assign rmii_master_clk_en         = st_r.clk_en;

endmodule
`default_nettype wire

// [rxpm_config_bank_props.sv]
// Purpose: port checks for the pattern mask and start configuration bank
// Assumes: sees only the top ports, one clock domain
// Notes: byte answers compared against a one-cycle copy of the query
`timescale 1ns/1ps
`default_nettype none
module rxpm_config_bank_props
	import rxpm_pkg::*;
(
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// management side
	input wire logic                 mgmt_req,
	input wire logic                 mgmt_write,
	input wire logic [DEV_W-1:0]     mmd_device_select,
	input wire logic [ADDR_W-1:0]    mgmt_addr,
	input wire logic                 mgmt_rvalid,
	input wire logic [DATA_W-1:0]    mgmt_rdata,
	// medium attachment area
	input wire logic                 pma_req,
	input wire logic [ADDR_W-1:0]    pma_addr,
	input wire logic                 pma_rvalid,
	input wire logic [DATA_W-1:0]    pma_rdata,
	// configuration and pin
	input wire logic [PAT_BYTES-1:0] pattern_mask,
	input wire logic [START_W-1:0]   compare_start,
	input wire logic [LPWR_W-1:0]    low_power_signal_mode,
	input wire logic                 low_power_signal_scrambled,
	input wire logic                 rx_data_bit_three_in,
	input wire logic                 receive_data_bit_three,
	input wire logic                 rmii_master_clk_en,
	// byte query
	input wire logic                 byte_query_valid,
	input wire logic [IDX_W-1:0]     byte_query_idx,
	input wire logic                 byte_ans_valid,
	input wire logic                 byte_ans_masked,
	input wire logic                 byte_ans_in_window
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// a local read; it outranks a returning medium answer in the same cycle
	wire lrd = mgmt_req && !mgmt_write && mmd_device_select != DEV_PMA;
	logic exp_mask_r;
	logic exp_win_r;
	// expected byte answer, held one cycle to meet the registered answer
	always_ff @(posedge clk) begin
		exp_mask_r <= pattern_mask[byte_query_idx];
		exp_win_r  <= byte_query_idx >= compare_start;
	end
	////////////////////////////////////////////////////////////////////////////////
	read_answer_a: assert property (lrd |=> mgmt_rvalid)
		else $error("local read gave no answer");
	pma_forward_a: assert property (mgmt_req && mmd_device_select == DEV_PMA
		|=> pma_req && pma_addr == $past(mgmt_addr)) else $error("access not forwarded");
	pma_return_a: assert property (pma_rvalid && !lrd
		|=> mgmt_rvalid && mgmt_rdata == $past(pma_rdata)) else $error("answer not returned");
	byte_mask_a: assert property (byte_query_valid
		|=> byte_ans_valid && byte_ans_masked == exp_mask_r) else $error("wrong mask bit");
	byte_window_a: assert property (byte_query_valid
		|=> byte_ans_in_window == exp_win_r) else $error("wrong compare window");
	scramble_sel_a: assert property (!$past(rst) |-> low_power_signal_scrambled ==
		($past(low_power_signal_mode) == LPWR_SCRAMBLED)) else $error("wrong scramble select");
	clock_toggle_a: assert property (!$past(rst, 2) && $past(rmii_master_clk_en, 2) &&
		$past(rmii_master_clk_en) && rmii_master_clk_en && $changed(receive_data_bit_three)
		##1 rmii_master_clk_en [*2] |-> $changed(receive_data_bit_three)
		&& $past(receive_data_bit_three) == $past(receive_data_bit_three, 2))
		else $error("pin clock not 50 MHz");
	data_path_a: assert property (!$past(rst) && !rmii_master_clk_en
		&& !$past(rmii_master_clk_en) |-> receive_data_bit_three == $past(rx_data_bit_three_in))
		else $error("pin not following data");
endmodule
bind rxpm_config_bank rxpm_config_bank_props u_props (.*);
`default_nettype wire

// [rxpm_config_bank_test.sv]
// Purpose: register and pin tests for the pattern mask configuration bank
// Assumes: one-cycle request strobes, answers registered on the taking edge and checked 1 ns after it
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module rxpm_config_bank_test
	import rxpm_pkg::*;
;
	logic                 clk, rst, mgmt_req, mgmt_write, mgmt_rvalid, pma_req, pma_write;
	logic                 pma_rvalid, rx_data_bit_three_in, receive_data_bit_three;
	logic                 rmii_master_clk_en, low_power_signal_scrambled, byte_query_valid;
	logic                 byte_ans_valid, byte_ans_masked, byte_ans_in_window;
	logic [CLKSEL_W-1:0]  clksel_strap;
	logic [DEV_W-1:0]     mmd_device_select;
	logic [ADDR_W-1:0]    mgmt_addr, pma_addr;
	logic [DATA_W-1:0]    mgmt_wdata, mgmt_rdata, pma_wdata, pma_rdata, rv;
	logic [PAT_BYTES-1:0] pattern_mask;
	logic [START_W-1:0]   compare_start;
	logic [LPWR_W-1:0]    low_power_signal_mode;
	logic [IDX_W-1:0]     byte_query_idx;
	int                   num_errors = 0, cmp_count = 0, n;

	rxpm_config_bank u_dut (
		.clk                        (clk),
		.rst                        (rst),
		.clksel_strap               (clksel_strap),
		.mgmt_req                   (mgmt_req),
		.mgmt_write                 (mgmt_write),
		.mmd_device_select          (mmd_device_select),
		.mgmt_addr                  (mgmt_addr),
		.mgmt_wdata                 (mgmt_wdata),
		.mgmt_rvalid                (mgmt_rvalid),
		.mgmt_rdata                 (mgmt_rdata),
		.pma_req                    (pma_req),
		.pma_write                  (pma_write),
		.pma_addr                   (pma_addr),
		.pma_wdata                  (pma_wdata),
		.pma_rvalid                 (pma_rvalid),
		.pma_rdata                  (pma_rdata),
		.pattern_mask               (pattern_mask),
		.compare_start              (compare_start),
		.low_power_signal_scrambled (low_power_signal_scrambled),
		.low_power_signal_mode      (low_power_signal_mode),
		.rx_data_bit_three_in       (rx_data_bit_three_in),
		.receive_data_bit_three     (receive_data_bit_three),
		.rmii_master_clk_en         (rmii_master_clk_en),
		.byte_query_valid           (byte_query_valid),
		.byte_query_idx             (byte_query_idx),
		.byte_ans_valid             (byte_ans_valid),
		.byte_ans_masked            (byte_ans_masked),
		.byte_ans_in_window         (byte_ans_in_window)
	);
	////////////////////////////////////////////////////////////////////////////////
	always #2.5 clk = ~clk;
	// a hang costs a mismatch; the run needs well under 2000 cycles
	initial begin
		#10000;
		num_errors++;
		end_of_test();
	end
	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one request pulse; write data goes to its inverse once released
	task automatic mreq(input logic w, input logic [DEV_W-1:0] d, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd);
		@(posedge clk); #1;
		{mgmt_req, mgmt_write, mmd_device_select, mgmt_addr, mgmt_wdata} = {1'b1, w, d, a, wd};
		@(posedge clk); #1;
		mgmt_req = 1'b0;
		mgmt_wdata = ~wd;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		mreq(1'b1, 5'h00, a, wd);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		mreq(1'b0, 5'h00, a, 16'h0000);
		chk("rvalid", 1'b1, mgmt_rvalid);
		chk("rdata", exp, mgmt_rdata);
	endtask
	task automatic q(input logic [IDX_W-1:0] i, input logic m, input logic w);
		@(posedge clk); #1;
		{byte_query_valid, byte_query_idx} = {1'b1, i};
		@(posedge clk); #1;
		byte_query_valid = 1'b0;
		chk("byte answer", {1'b1, m, w}, {byte_ans_valid, byte_ans_masked, byte_ans_in_window});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, mgmt_req, mgmt_write, pma_rvalid, rx_data_bit_three_in, byte_query_valid} = '0;
		{clksel_strap, mmd_device_select, mgmt_addr, mgmt_wdata, pma_rdata, byte_query_idx} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		// reset values
		for (n = 0; n < MASK_REGS; n++) rd(ADDR_W'(OFS_MASK_BASE + n), RST_MASK);
		rd(OFS_START, 16'h0000);
		rd(OFS_LOW_PWR, RST_LPWR);
		rd(OFS_PIN_FUNC, 16'h0000);
		// a distinct pattern per mask register, checked per byte at both ends
		for (n = 0; n < MASK_REGS; n++) wr(ADDR_W'(OFS_MASK_BASE + n), 16'h8001);
		for (n = 0; n < MASK_REGS; n++) begin
			rv = (16'h0001 << n) | (16'h8000 >> n);
			wr(ADDR_W'(OFS_MASK_BASE + n), rv);
			rd(ADDR_W'(OFS_MASK_BASE + n), rv);
			chk("mask", rv, pattern_mask[n*16 +: 16]);
			q(IDX_W'(n * 17), 1'b1, 1'b1);
			q(IDX_W'(n * 17 + 1), 1'b0, 1'b1);
			q(IDX_W'(n * 15 + 15), 1'b1, 1'b1);
		end
		// start point: upper bits dropped, window edge at the boundary
		wr(OFS_START, 16'hffcc);
		rd(OFS_START, 16'h000c);
		chk("start", START_PAST_ADDR, compare_start);
		q(6'h0b, 1'b0, 1'b0);
		q(6'h0c, 1'b0, 1'b1);
		wr(OFS_START, 16'h0001);
		q(6'h00, 1'b1, 1'b0);
		q(6'h01, 1'b0, 1'b1);
		// pin as 50 MHz clock, then back to data
		wr(OFS_PIN_FUNC, 16'h5a03);
		rd(OFS_PIN_FUNC, 16'h5a03);
		chk("clk_en", 1'b1, rmii_master_clk_en);
		n = 0;
		repeat (8) begin
			rv[0] = receive_data_bit_three;
			@(posedge clk); #1;
			n += int'(rv[0] !== receive_data_bit_three);
		end
		chk("toggles", 4, n);
		wr(OFS_PIN_FUNC, 16'h0000);
		for (n = 0; n < 2; n++) begin
			rx_data_bit_three_in = n[0];
			repeat (2) @(posedge clk);
			#1;
			chk("pin", {1'b0, n[0]}, {rmii_master_clk_en, receive_data_bit_three});
		end
		// every low power signal mode code
		for (n = 0; n < 4; n++) begin
			wr(OFS_LOW_PWR, {6'h00, n[1:0], 8'hc3});
			@(posedge clk); #1;
			chk("low power mode", {n[1:0], n == 3},
				{low_power_signal_mode, low_power_signal_scrambled});
		end
		rd(16'h04d0, 16'h0000);
		// device select 1 forwarded and answered, local bank untouched
		mreq(1'b1, DEV_PMA, OFS_START, 16'h003f);
		chk("pma_wr", {1'b1, 1'b1, OFS_START, 16'h003f}, {pma_req, pma_write, pma_addr, pma_wdata});
		mreq(1'b0, DEV_PMA, 16'h0007, 16'h0000);
		chk("pma_rd", {1'b1, 1'b0, 16'h0007}, {pma_req, pma_write, pma_addr});
		{pma_rvalid, pma_rdata} = {1'b1, 16'h003d};
		@(posedge clk); #1;
		{pma_rvalid, pma_rdata} = {1'b0, 16'hffc2};
		chk("pma_ans", {1'b1, 16'h003d}, {mgmt_rvalid, mgmt_rdata});
		chk("start kept", 6'h01, compare_start);
		// second reset with the clock strap
		clksel_strap = CLKSEL_CLK50;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		rd(OFS_PIN_FUNC, 16'h0003);
		rd(OFS_MASK_16_31, RST_MASK);
		chk("clk_en", 1'b1, rmii_master_clk_en);
		end_of_test();
	end
endmodule
`default_nettype wire

// [rxpm_pkg.sv]
// Purpose: constants for the receive pattern mask and start configuration bank
// Assumes: 16-bit management words, word-addressed register space
// Notes: one clock, synchronous active-high reset
`default_nettype none
package rxpm_pkg;

	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 16;
	localparam int DEV_W      = 5;
	localparam int MASK_REGS  = 4;
	localparam int PAT_BYTES  = MASK_REGS * DATA_W;
	localparam int IDX_W      = 6;

	// register offsets in the main space
	localparam logic [ADDR_W-1:0] OFS_MASK_BASE   = 16'h04c8;
	localparam logic [ADDR_W-1:0] OFS_MASK_16_31  = 16'h04c9;
	localparam logic [ADDR_W-1:0] OFS_MASK_32_47  = 16'h04ca;
	localparam logic [ADDR_W-1:0] OFS_MASK_48_63  = 16'h04cb;
	localparam logic [ADDR_W-1:0] OFS_START       = 16'h04cc;
	localparam logic [ADDR_W-1:0] OFS_PIN_FUNC    = 16'h04e0;
	localparam logic [ADDR_W-1:0] OFS_LOW_PWR     = 16'h04e5;

	// device select that reaches the medium attachment area
	localparam logic [DEV_W-1:0]  DEV_PMA         = 5'h01;

	// field positions
	localparam int START_LSB = 0;
	localparam int START_W   = 6;
	localparam int CLKSEL_W  = 3;
	localparam int LPWR_LSB  = 8;
	localparam int LPWR_W    = 2;

	// reset values
	localparam logic [DATA_W-1:0]  RST_MASK  = 16'h0000;
	localparam logic [START_W-1:0] RST_START = 6'h00;
	localparam logic [DATA_W-1:0]  RST_LPWR  = 16'h00c3;

	// meaningful field codes
	localparam logic [START_W-1:0]  START_PAST_ADDR = 6'h0c;
	localparam logic [CLKSEL_W-1:0] CLKSEL_DATA     = 3'h0;
	localparam logic [CLKSEL_W-1:0] CLKSEL_CLK50    = 3'h3;
	localparam logic [LPWR_W-1:0]   LPWR_SCRAMBLED  = 2'h3;

	// clock output timing: 50 MHz from a 200 MHz clock, toggled every half period
	localparam int CLK_HZ        = 200_000_000;
	localparam int CLKOUT_HZ     = 50_000_000;
	localparam int CLKOUT_HALF   = CLK_HZ / (2 * CLKOUT_HZ);
	localparam int DIV_W         = 2;

endpackage
`default_nettype wire
